// ===== design/seg_gpio_port.v
// How it works
// RQ1 - Eight pins, one bit each per register
// RQ2 - Direction register write-only, reads return zero
// RQ3 - Direction one drives output, zero is input
// RQ4 - Output pins drive the output latch bit
// RQ5 - Readback of output pins returns latch value
// RQ6 - Readback of input pins returns sampled pin
// RQ7 - Pin n carries LCD segment n plus 33
// RQ8 - Codes 0001, 001X, 010X give pins to segments
// RQ9 - Other codes use direction bits; reset zero
`timescale 1ns/100ps
`include "seg_gpio_port_regs.vh"
module seg_gpio_port #(
    parameter WIDTH = 8
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire [3:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire wr_en_i,
    input wire rd_en_i,
    output reg [7:0] rd_data_o,
    input wire [3:0] segment_select_field_i,
    input wire [WIDTH-1:0] lcd_segment_output_i,
    input wire [WIDTH-1:0] pin_in_i,
    output reg [WIDTH-1:0] pin_out_o,
    output reg [WIDTH-1:0] pin_oe_o
);

    // Software-visible state, one bit per pin at the same position
    reg [WIDTH-1:0] pin_direction_r;
    reg [WIDTH-1:0] pin_direction_nxt;
    reg [WIDTH-1:0] output_latch_r;
    reg [WIDTH-1:0] output_latch_nxt;

    // Bus decode strobes
    reg dir_wr_hit;
    reg latch_wr_hit;
    reg dir_rd_hit;
    reg latch_rd_hit;
    reg state_rd_hit;

    // Pin side: synced level, readback and next drive
    wire [WIDTH-1:0] pin_level;
    wire [WIDTH-1:0] pin_state_readback;
    wire [WIDTH-1:0] pin_out_nxt;
    wire [WIDTH-1:0] pin_oe_nxt;

    // Segment hand-over flag and read path
    reg seg_mode;
    reg [7:0] rd_data_nxt;

    // Pins come from outside the clock domain
    pin_sync #(
        .WIDTH(WIDTH)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .async_i(pin_in_i),
        .sync_o(pin_level)
    );

    // Address decode; the master never raises both strobes at once
    always @* begin
        dir_wr_hit = 1'b0;
        latch_wr_hit = 1'b0;
        dir_rd_hit = 1'b0;
        latch_rd_hit = 1'b0;
        state_rd_hit = 1'b0;
        case (addr_i)
            `PIN_DIRECTION_ADDR: begin
                dir_wr_hit = wr_en_i;
                dir_rd_hit = rd_en_i;
            end
            `OUTPUT_LATCH_ADDR: begin
                latch_wr_hit = wr_en_i;
                latch_rd_hit = rd_en_i;
            end
            `PIN_STATE_READBACK_ADDR: begin
                state_rd_hit = rd_en_i; // Writes here are ignored
            end
            default: begin
                state_rd_hit = 1'b0;
            end
        endcase
    end

    // Direction next value; only its own address writes it
    always @* begin
        pin_direction_nxt = pin_direction_r;
        if (dir_wr_hit) begin
            pin_direction_nxt = wr_data_i[WIDTH-1:0]; // RQ1
        end
    end

    // Direction register
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            pin_direction_r <= `PIN_DIRECTION_RST; // RQ9
        end else begin
            pin_direction_r <= pin_direction_nxt;
        end
    end

    // Latch next value; its own address writes it whatever the pin direction or segment mode
    always @* begin
        output_latch_nxt = output_latch_r;
        if (latch_wr_hit) begin
            output_latch_nxt = wr_data_i[WIDTH-1:0]; // RQ4
        end
    end

    // Output latch register
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            output_latch_r <= `OUTPUT_LATCH_RST; // RQ9
        end else begin
            output_latch_r <= output_latch_nxt;
        end
    end

    // Segment-select decode; codes outside the three groups keep the port as GPIO
    always @* begin
        case (segment_select_field_i)
            4'h0: seg_mode = 1'b0; // RQ9
            `SEG_SEL_ONE: seg_mode = 1'b1; // RQ8
            {`SEG_SEL_01X, 1'b0}: seg_mode = 1'b1; // RQ8
            {`SEG_SEL_01X, 1'b1}: seg_mode = 1'b1;
            {`SEG_SEL_10X, 1'b0}: seg_mode = 1'b1;
            {`SEG_SEL_10X, 1'b1}: seg_mode = 1'b1;
            4'h6: seg_mode = 1'b0;
            4'h7: seg_mode = 1'b0;
            4'h8: seg_mode = 1'b0;
            4'h9: seg_mode = 1'b0;
            4'ha: seg_mode = 1'b0;
            4'hb: seg_mode = 1'b0;
            4'hc: seg_mode = 1'b0;
            4'hd: seg_mode = 1'b0;
            4'he: seg_mode = 1'b0;
            4'hf: seg_mode = 1'b0;
            default: seg_mode = 1'b0;
        endcase
    end

    // Per-pin readback and drive; segment n plus 33 sits on pin n
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
            // Combinational bits of this pin
            reg state_bit;
            reg out_bit;
            reg oe_bit;

            // Output pins echo the latch, input pins the synced level
            always @* begin
                if (pin_direction_r[gi]) begin
                    state_bit = output_latch_r[gi]; // RQ5
                end else begin
                    state_bit = pin_level[gi]; // RQ6
                end
            end

            // Segments drive every pin whatever its direction bit
            always @* begin
                if (seg_mode) begin
                    out_bit = lcd_segment_output_i[gi]; // RQ7
                    oe_bit = 1'b1; // RQ8
                end else begin
                    out_bit = output_latch_r[gi]; // RQ4
                    oe_bit = pin_direction_r[gi]; // RQ3
                end
            end

            // Gather the bits back into vectors
            assign pin_state_readback[gi] = state_bit;
            assign pin_out_nxt[gi] = out_bit;
            assign pin_oe_nxt[gi] = oe_bit;
        end
    endgenerate

    // Read mux; direction reads give zero since the register is write-only
    always @* begin
        rd_data_nxt = 8'h00;
        if (dir_rd_hit) begin
            rd_data_nxt = 8'h00; // RQ2
        end else if (latch_rd_hit) begin
            rd_data_nxt = output_latch_r;
        end else if (state_rd_hit) begin
            rd_data_nxt = pin_state_readback;
        end else begin
            rd_data_nxt = 8'h00;
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= rd_data_nxt;
        end
    end

    // Pin value; lags the control by one cycle
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            pin_out_o <= {WIDTH{1'b0}};
        end else begin
            pin_out_o <= pin_out_nxt;
        end
    end

    // Pin enable; low from reset so nothing drives until software asks
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            pin_oe_o <= {WIDTH{1'b0}};
        end else begin
            pin_oe_o <= pin_oe_nxt; // RQ9
        end
    end

endmodule

// ===== inc/seg_gpio_port_regs.vh
`ifndef SEG_GPIO_PORT_REGS_VH
`define SEG_GPIO_PORT_REGS_VH

// Register addresses on the plain register port
`define PIN_DIRECTION_ADDR 4'h0
`define OUTPUT_LATCH_ADDR 4'h1
`define PIN_STATE_READBACK_ADDR 4'h2

// Reset values
`define PIN_DIRECTION_RST 8'h00
`define OUTPUT_LATCH_RST 8'h00

// Segment-select field codes that hand the pins to the LCD segments
`define SEG_SEL_ONE 4'h1
`define SEG_SEL_01X 3'h1
`define SEG_SEL_10X 3'h2

// Segment numbering: pin n carries segment n plus this offset
`define SEG_FIRST 33

`endif

// ===== design/pin_sync.v
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 8
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_r;

    // Two stages; only the second stage is read outside
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            meta_r <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

// ===== testbench/pin_model.sv
`timescale 1ns/100ps
module pin_model(input wire [7:0] out_i,oe_i,ext_i,output wire [7:0] pin_o);
// Driven pins show the port, the rest the outside level
assign pin_o=(oe_i&out_i)|(~oe_i&ext_i);
endmodule

// ===== testbench/seg_gpio_port_properties.sv
`timescale 1ns/100ps
module seg_gpio_port_properties(input wire mclk_i,rstn_i,wr_en_i,rd_en_i,input wire [3:0] addr_i,
segment_select_field_i,input wire [7:0] wr_data_i,rd_data_o,lcd_segment_output_i,pin_in_i,pin_out_o,pin_oe_o);
// Codes 1 to 5 give pins to segments; zero wraps out of range
wire sm=(segment_select_field_i-4'h1)<4'h5;
wire r0=rd_en_i&&addr_i==4'h0,rb=rd_en_i&&addr_i==4'h2&&!sm;
default clocking @(posedge mclk_i);endclocking
default disable iff(!rstn_i);
sequence s_wdir;wr_en_i&&addr_i==4'h0 ##1 !sm&&!(wr_en_i&&addr_i==4'h0);endsequence
property p_dir;s_wdir|=>pin_oe_o==$past(wr_data_i,2);endproperty
a_dir:assert property(p_dir)else $error("dir");
property p_seg;sm|=>pin_oe_o==8'hff&&pin_out_o==$past(lcd_segment_output_i);endproperty
a_seg:assert property(p_seg)else $error("seg");
property p_out;rb|=>(rd_data_o&pin_oe_o)==(pin_out_o&pin_oe_o);endproperty
a_out:assert property(p_out)else $error("out");
property p_in;rb|=>(rd_data_o&~pin_oe_o)==($past(pin_in_i,3)&~pin_oe_o);endproperty
a_in:assert property(p_in)else $error("in");
property p_ddr;r0|=>rd_data_o==8'h00;endproperty
a_ddr:assert property(p_ddr)else $error("ddr");
property p_lat;wr_en_i&&addr_i==4'h1 ##1 rd_en_i&&addr_i==4'h1|=>rd_data_o==$past(wr_data_i,2);endproperty
a_lat:assert property(p_lat)else $error("lat");
property p_rst;$rose(rstn_i)|->pin_oe_o==8'h00&&pin_out_o==8'h00;endproperty
a_rst:assert property(p_rst)else $error("rst");
property p_idle;!rd_en_i|=>rd_data_o==8'h00;endproperty
a_idle:assert property(p_idle)else $error("idle");
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
reg mclk_i=0,rstn_i=0,wr_en_i=0,rd_en_i=0;
reg [3:0] addr_i=4'h0,segment_select_field_i=4'h0;
reg [7:0] wr_data_i=8'h00,lcd_segment_output_i=8'h1e,ext=8'h3c;// 1e is not bit-symmetric, 3c is: a swapped pin order shows on the segments
wire [7:0] rd_data_o,pin_in_i,pin_out_o,pin_oe_o;
integer fails=0,checked=0,c;
seg_gpio_port dut(.*);
pin_model pm(.out_i(pin_out_o),.oe_i(pin_oe_o),.ext_i(ext),.pin_o(pin_in_i));
initial forever #50 mclk_i=~mclk_i;
// One bus cycle; the next call overrides, so strobes stay one cycle
task bus(input w,r,input [3:0] a,input [7:0] d);
@(posedge mclk_i) begin wr_en_i<=w;rd_en_i<=r;addr_i<=a;wr_data_i<=d;end
endtask
task chk(input string n,input [7:0] s,e);
checked++;
if(s!==e) begin fails++;$display("unexpected %s exp %h got %h",n,e,s);end
endtask
task rd(input [3:0] a,input [7:0] e);
bus(0,1,a,8'h00);bus(0,0,a,8'h00);#1 chk("rd_data_o",rd_data_o,e);
endtask
// Low nibble out, high nibble in; readback mixes latch and pins
task t_gpio;
bus(1,0,4'h0,8'h0f);bus(1,0,4'h1,8'ha5);rd(4'h1,8'ha5);
rd(4'h2,8'h35);
rd(4'h0,8'h00);
rd(4'h3,8'h00);
endtask
// Every field code, segments must win over the direction bits
task t_seg;
for(c=0;c<16;c++) begin
@(posedge mclk_i) segment_select_field_i<=c[3:0];bus(0,0,4'h0,8'h00);#1
chk("pin_oe_o",pin_oe_o,(c>0&&c<6)?8'hff:8'h0f);
chk("pin_out_o",pin_out_o&pin_oe_o,(c>0&&c<6)?8'h1e:8'h05);
end
endtask
// Reset in mid-run must clear direction and latch again
task t_rst;
@(posedge mclk_i) rstn_i<=0;repeat(3) @(posedge mclk_i);rstn_i<=1;
rd(4'h1,8'h00);chk("pin_oe_o",pin_oe_o,8'h00);
endtask
initial begin
repeat(8) @(posedge mclk_i);
rstn_i<=1;rd(4'h1,8'h00);
t_gpio;t_seg;t_rst;results;
end
// Run needs under 100 cycles; 1000 means a hang
initial begin #100000;fails++;results;end
task results;
if(fails==0&&checked>0) $display("bench passed");
else $display("bench failed");
$finish;
endtask
endmodule
bind seg_gpio_port seg_gpio_port_properties chk(.*);
